// ===== tcc_pkg.sv
// Constants shared by the capture/compare value block
package tcc_pkg;
    localparam int unsigned NUM_CH = 3;
    localparam int unsigned VAL_W = 16;
    localparam int unsigned ADDR_W = 8;
    localparam logic [7:0] COMPARE_VALUE_CH1_OFS = 8'h34;
    localparam logic [7:0] COMPARE_VALUE_CH2_OFS = 8'h38;
    localparam logic [7:0] COMPARE_VALUE_CH3_OFS = 8'h3C;
    localparam logic [15:0] VALUE_RESET = 16'h0000;
    localparam logic [15:0] RESERVED_READ = 16'h0000;
endpackage

// ===== tcc_values.sv
// Value registers, preload, compare and capture for three channels
`timescale 1ns/100ps

module tcc_values #(
    parameter int unsigned VAL_W = tcc_pkg::VAL_W
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [31:0] rdata,
    input wire logic [VAL_W-1:0] main_counter_value,
    input wire logic update_event,
    input wire logic [2:0] ch_is_input,
    input wire logic ch1_preload_enable,
    input wire logic ch2_preload_enable,
    input wire logic ch3_preload_enable,
    input wire logic ch1_capture_event,
    input wire logic ch2_capture_event,
    input wire logic ch3_capture_event,
    output logic ch1_compare_output,
    output logic ch2_compare_output,
    output logic ch3_compare_output,
    output logic [VAL_W-1:0] ch1_active_value,
    output logic [VAL_W-1:0] ch2_active_value,
    output logic [VAL_W-1:0] ch3_active_value
);

    logic [VAL_W-1:0] value_q [3];
    logic [VAL_W-1:0] active_q [3];
    logic [2:0] cmp_q;
    logic [31:0] rdata_q;
    wire [2:0] sel;
    wire [2:0] pe;
    wire [2:0] cap;
    wire hit;
    wire [VAL_W-1:0] rd_val;

    // Full byte-offset match, so no register aliases into a neighbour
    function automatic logic offset_match(
        input logic [tcc_pkg::ADDR_W-1:0] a,
        input logic [tcc_pkg::ADDR_W-1:0] ofs
    );
        return a == ofs;
    endfunction

    assign sel[0] = offset_match(addr, tcc_pkg::COMPARE_VALUE_CH1_OFS);
    assign sel[1] = offset_match(addr, tcc_pkg::COMPARE_VALUE_CH2_OFS);
    assign sel[2] = offset_match(addr, tcc_pkg::COMPARE_VALUE_CH3_OFS);
    assign hit = |sel;
    assign pe = {ch3_preload_enable, ch2_preload_enable, ch1_preload_enable};
    assign cap = {ch3_capture_event, ch2_capture_event, ch1_capture_event};
    // Unmapped addresses read as zero
    assign rd_val = sel[0] ? value_q[0] :
                    sel[1] ? value_q[1] :
                    sel[2] ? value_q[2] : '0;

    for (genvar i = 0; i < 3; i++) begin : g_ch
        // Capture wins over a same-cycle software write on input channels
        always_ff @(posedge ref_clk or posedge reset) begin
            if (reset) begin
                value_q[i] <= tcc_pkg::VALUE_RESET;
            end else if (clk_en) begin
                if (ch_is_input[i] && cap[i]) begin
                    value_q[i] <= main_counter_value;
                end else if (wr_stb && sel[i]) begin
                    value_q[i] <= wdata[VAL_W-1:0];
                end
            end
        end

        always_ff @(posedge ref_clk or posedge reset) begin
            if (reset) begin
                active_q[i] <= tcc_pkg::VALUE_RESET;
            end else if (clk_en && !ch_is_input[i]) begin
                if (!pe[i]) begin
                    active_q[i] <= value_q[i];
                end else if (update_event) begin
                    active_q[i] <= value_q[i];
                end
            end
        end

        // Registered match: one cycle late, but free of decode glitches
        always_ff @(posedge ref_clk or posedge reset) begin
            if (reset) begin
                cmp_q[i] <= 1'b0;
            end else if (clk_en) begin
                cmp_q[i] <= !ch_is_input[i] &&
                    (main_counter_value == active_q[i]);
            end
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            rdata_q <= {tcc_pkg::RESERVED_READ, tcc_pkg::VALUE_RESET};
        end else if (clk_en && rd_stb) begin
            rdata_q <= {tcc_pkg::RESERVED_READ, rd_val};
        end
    end

    assign rdata = rdata_q;
    assign ch1_compare_output = cmp_q[0];
    assign ch2_compare_output = cmp_q[1];
    assign ch3_compare_output = cmp_q[2];
    assign ch1_active_value = active_q[0];
    assign ch2_active_value = active_q[1];
    assign ch3_active_value = active_q[2];

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    sequence s_write1;
        clk_en && wr_stb && sel[0] && !ch_is_input[0] && !pe[0];
    endsequence

    a_direct_load: assert property (
        s_write1 ##1 (clk_en && !ch_is_input[0] && !pe[0])
        |=> active_q[0] == $past(wdata[VAL_W-1:0], 2))
        else $error("active value not loaded directly");
    a_preload_hold: assert property (
        clk_en && pe[1] && !update_event && !ch_is_input[1]
        |=> $stable(active_q[1]))
        else $error("active value changed without update");
    a_preload_update: assert property (
        clk_en && pe[2] && update_event && !ch_is_input[2]
        |=> active_q[2] == $past(value_q[2]))
        else $error("update did not copy preload");
    a_capture_value: assert property (
        clk_en && ch_is_input[0] && cap[0]
        |=> value_q[0] == $past(main_counter_value))
        else $error("capture value wrong");
    a_write_store: assert property (
        clk_en && wr_stb && sel[1] && !(ch_is_input[1] && cap[1])
        |=> value_q[1] == $past(wdata[VAL_W-1:0]))
        else $error("write not stored");
    a_compare_out: assert property (
        clk_en && !ch_is_input[0] && main_counter_value == active_q[0]
        |=> ch1_compare_output)
        else $error("compare output missing");
    a_read_upper: assert property (
        clk_en && rd_stb |=> rdata[31:16] == tcc_pkg::RESERVED_READ)
        else $error("reserved bits not zero");
    a_read_ch3: assert property (
        clk_en && rd_stb && addr == tcc_pkg::COMPARE_VALUE_CH3_OFS
        && !wr_stb && !cap[2]
        |=> rdata[VAL_W-1:0] == value_q[2])
        else $error("channel three read wrong");
    a_read_unmapped: assert property (
        clk_en && rd_stb && !hit |=> rdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_rdata_hold: assert property (
        !(clk_en && rd_stb) |=> $stable(rdata))
        else $error("read data changed without a read");
    a_unmapped_write: assert property (
        clk_en && wr_stb && !hit && !(|(ch_is_input & cap))
        |=> $stable(value_q[0]) && $stable(value_q[1])
            && $stable(value_q[2]))
        else $error("unmapped write changed a register");

    // Same checks on every channel, so no channel is left unwatched
    for (genvar j = 0; j < 3; j++) begin : g_chk
        sequence s_store;
            clk_en && wr_stb && sel[j] && !(ch_is_input[j] && cap[j]);
        endsequence

        sequence s_capture;
            clk_en && ch_is_input[j] && cap[j];
        endsequence

        sequence s_direct;
            clk_en && !ch_is_input[j] && !pe[j];
        endsequence

        a_store_each: assert property (
            s_store |=> value_q[j] == $past(wdata[VAL_W-1:0]))
            else $error("write not stored in channel");

        a_capture_each: assert property (
            s_capture |=> value_q[j] == $past(main_counter_value))
            else $error("capture not stored in channel");

        a_follow_each: assert property (
            s_direct |=> active_q[j] == $past(value_q[j]))
            else $error("active value does not follow register");

        a_hold_each: assert property (
            clk_en && !ch_is_input[j] && pe[j] && !update_event
            |=> $stable(active_q[j]))
            else $error("active value moved without update");

        a_input_keep: assert property (
            clk_en && ch_is_input[j] |=> $stable(active_q[j]))
            else $error("active value moved in input mode");

        a_match_each: assert property (
            clk_en && !ch_is_input[j] && main_counter_value == active_q[j]
            |=> cmp_q[j])
            else $error("compare output missing on match");

        a_miss_each: assert property (
            clk_en && (ch_is_input[j] || main_counter_value != active_q[j])
            |=> !cmp_q[j])
            else $error("compare output without a match");

        a_read_each: assert property (
            clk_en && rd_stb && sel[j]
            |=> rdata[VAL_W-1:0] == $past(value_q[j]))
            else $error("read data differs from register");

        a_freeze_each: assert property (
            !clk_en |=> $stable(value_q[j]) && $stable(active_q[j])
                && $stable(cmp_q[j]))
            else $error("state moved while clock enable low");
    end

endmodule

// ===== tcc_values_test.sv
// Self-checking testbench for the channel value registers
`timescale 1ns/100ps
module tcc_values_test;
    localparam logic [31:0] ZERO = 32'h0000_0000;
    logic ref_clk, reset, clk_en, wr_stb, rd_stb, upd;
    logic [7:0] addr;
    logic [31:0] wdata, rdata;
    logic [15:0] cnt, act1, act2, act3;
    logic [2:0] is_in, pre, cap, cmp;
    int n_mismatch = 0;
    int n_checks = 0;
    tcc_values i_dut (.ref_clk(ref_clk), .reset(reset), .clk_en(clk_en),
        .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
        .rdata(rdata), .main_counter_value(cnt), .update_event(upd),
        .ch_is_input(is_in), .ch1_preload_enable(pre[0]),
        .ch2_preload_enable(pre[1]), .ch3_preload_enable(pre[2]),
        .ch1_capture_event(cap[0]), .ch2_capture_event(cap[1]),
        .ch3_capture_event(cap[2]), .ch1_compare_output(cmp[0]),
        .ch2_compare_output(cmp[1]), .ch3_compare_output(cmp[2]),
        .ch1_active_value(act1), .ch2_active_value(act2),
        .ch3_active_value(act3));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge ref_clk);
        wr_stb <= 1'b0;
    endtask
    // Read data appears in the cycle after the strobe and holds until the next read
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge ref_clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge ref_clk);
        rd_stb <= 1'b0;
        #1 chk(rdata, e);
    endtask
    task automatic complete_run;
        if (n_mismatch == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    // Whole sequence needs well under 100 cycles
    initial begin
        #20000;
        n_mismatch++;
        complete_run();
    end
    initial begin
        reset = 1'b1;
        clk_en = 1'b1;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        upd = 1'b0;
        addr = 8'h00;
        wdata = ZERO;
        cnt = 16'h0000;
        is_in = 3'h0;
        pre = 3'h2;
        cap = 3'h0;
        repeat (10) @(posedge ref_clk);
        reset <= 1'b0;
        rd(8'h34, ZERO);
        rd(8'h38, ZERO);
        rd(8'h3C, ZERO);
        rd(8'h40, ZERO);
        // Upper halves stay zero: software keeps reserved bits at reset
        wr(8'h34, 32'h0000_1234);
        wr(8'h38, 32'h0000_0055);
        wr(8'h40, 32'h0000_7777);
        repeat (2) @(posedge ref_clk);
        #1 chk(32'(act1), 32'h0000_1234);
        chk(32'(act2), ZERO);
        rd(8'h34, 32'h0000_1234);
        rd(8'h38, 32'h0000_0055);
        rd(8'h3C, ZERO);
        rd(8'h40, ZERO);
        wr(8'h34, 32'h0000_4321);
        @(posedge ref_clk);
        #1 chk(32'(act1), 32'h0000_4321);
        // A write while the clock enable is low must be lost
        @(posedge ref_clk);
        clk_en <= 1'b0;
        wr(8'h34, 32'h0000_1234);
        clk_en <= 1'b1;
        rd(8'h34, 32'h0000_4321);
        chk(32'(act1), 32'h0000_4321);
        @(posedge ref_clk);
        upd <= 1'b1;
        cnt <= 16'h4321;
        @(posedge ref_clk);
        upd <= 1'b0;
        #1 chk(32'(act2), 32'h0000_0055);
        @(posedge ref_clk);
        #1 chk(32'(cmp), 32'h0000_0001);
        wr(8'h38, 32'h0000_0066);
        @(posedge ref_clk);
        #1 chk(32'(act2), 32'h0000_0055);
        rd(8'h38, 32'h0000_0066);
        @(posedge ref_clk);
        cnt <= 16'h0055;
        @(posedge ref_clk);
        #1 chk(32'(cmp), 32'h0000_0002);
        // Capture on channels one and three; capture beats the write
        @(posedge ref_clk);
        is_in <= 3'h5;
        cnt <= 16'hBEEF;
        cap <= 3'h5;
        addr <= 8'h3C;
        wdata <= 32'h0000_1111;
        wr_stb <= 1'b1;
        @(posedge ref_clk);
        cap <= 3'h0;
        wr_stb <= 1'b0;
        rd(8'h3C, 32'h0000_BEEF);
        rd(8'h34, 32'h0000_BEEF);
        chk(32'(act1), 32'h0000_4321);
        chk(32'(act3), ZERO);
        chk(32'(cmp), ZERO);
        @(posedge ref_clk);
        reset <= 1'b1;
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        rd(8'h3C, ZERO);
        rd(8'h38, ZERO);
        chk(32'(act2), ZERO);
        complete_run();
    end
endmodule
